// ---- src/trip_value_recorder_consts.svh ----
`ifndef TRIP_VALUE_RECORDER_CONSTS_SVH
`define TRIP_VALUE_RECORDER_CONSTS_SVH

// Sample and value widths
`define TVR_SW 16
`define TVR_RW 16
`define TVR_PW 32
`define TVR_BUS_W (3 * `TVR_SW)

// Times, in their own units
`define TVR_SAMPLE_PERIOD_US 1000
`define TVR_PREFAULT_MS 100
`define TVR_FAULT1_MS 10
`define TVR_FAULT2_MS 20

// Times as counts of samples
`define TVR_PRE_SAMPLES (`TVR_PREFAULT_MS * 1000 / `TVR_SAMPLE_PERIOD_US)
`define TVR_F1_SAMPLES (`TVR_FAULT1_MS * 1000 / `TVR_SAMPLE_PERIOD_US)
`define TVR_F2_SAMPLES (`TVR_FAULT2_MS * 1000 / `TVR_SAMPLE_PERIOD_US)

// History depth holds the newest sample plus the prefault reach
`define TVR_HIST_DEPTH (`TVR_PRE_SAMPLES + 1)
`define TVR_PTR_W 7
`define TVR_CNT_W 5

// Event sequence: three prefault records, then three fault records
`define TVR_REC_W 3
`define TVR_REC_LAST 5
`define TVR_REC_FAULT 3

`endif

// ---- src/tvr_pkg.sv ----
package tvr_pkg;
   typedef enum logic [2:0] {
      ST_IDLE = 3'h1,
      ST_WAIT = 3'h2,
      ST_EMIT = 3'h4
   } state_e;
endpackage

// ---- src/sample_history.sv ----
`timescale 1ns/1ps
`include "trip_value_recorder_consts.svh"
module sample_history (
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic wr_en,
   input wire logic [`TVR_BUS_W-1:0] wr_data,
   output logic [`TVR_BUS_W-1:0] oldest
);
   logic [`TVR_BUS_W-1:0] mem [0:`TVR_HIST_DEPTH-1];
   logic [`TVR_PTR_W-1:0] ptr;

   // Ring of flip-flops; the slot about to be overwritten is the oldest sample
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         for (int i = 0; i < `TVR_HIST_DEPTH; i++) begin
            mem[i] <= '0;
         end
      end else if (wr_en) begin
         mem[ptr] <= wr_data;
      end
   end

   // Write pointer wraps at the depth, which is not a power of two
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         ptr <= '0;
      end else if (wr_en) begin
         if (ptr == `TVR_PTR_W'(`TVR_HIST_DEPTH - 1)) begin
            ptr <= '0;
         end else begin
            ptr <= ptr + `TVR_PTR_W'(1);
         end
      end
   end

   assign oldest = mem[ptr];
endmodule

// ---- src/trip_value_recorder.sv ----
`timescale 1ns/1ps
`include "trip_value_recorder_consts.svh"
// Notes on behaviour
// - Each start rising edge latches prefault and fault values for all three channels.
// - After a start edge the block waits for the trip input.
// - A newer start edge before trip replaces the held values.
// - Prefault value is the sample 100 ms before the start edge, from a history.
// - Fault value is the mean of samples 10 ms and 20 ms after start.
// - Trip while values are held emits prefault and fault event records.
// - Values are scaled to primary side by the measurement chain ratios.
// - No binary outputs; the only results are the event records.
module trip_value_recorder
   import tvr_pkg::*;
(
   input wire logic ref_clk,
   input wire logic srst,
   input wire logic start,
   input wire logic trip,
   input wire logic sample_valid,
   input wire logic [`TVR_SW-1:0] sample_a,
   input wire logic [`TVR_SW-1:0] sample_b,
   input wire logic [`TVR_SW-1:0] sample_c,
   input wire logic [`TVR_RW-1:0] ratio_a,
   input wire logic [`TVR_RW-1:0] ratio_b,
   input wire logic [`TVR_RW-1:0] ratio_c,
   output logic event_valid,
   output logic event_fault,
   output logic [1:0] event_chan,
   output logic [`TVR_PW-1:0] event_value
);
   // Mean of two samples per channel; the sum keeps its carry
   function automatic logic [`TVR_BUS_W-1:0] mean_bus(input logic [`TVR_BUS_W-1:0] x,
                                                      input logic [`TVR_BUS_W-1:0] y);
      logic [`TVR_SW:0] s;
      mean_bus = '0;
      for (int i = 0; i < 3; i++) begin
         s = {1'b0, x[i*`TVR_SW +: `TVR_SW]} + {1'b0, y[i*`TVR_SW +: `TVR_SW]};
         mean_bus[i*`TVR_SW +: `TVR_SW] = s[`TVR_SW:1];
      end
   endfunction

   // Channel pick from a packed group of three
   function automatic logic [`TVR_SW-1:0] pick(input logic [`TVR_BUS_W-1:0] bus, input logic [1:0] ch);
      pick = bus[ch*`TVR_SW +: `TVR_SW];
   endfunction

   logic start_q;
   logic trip_q;
   logic start_edge;
   logic trip_edge;
   logic [`TVR_BUS_W-1:0] sample_bus;
   logic [`TVR_BUS_W-1:0] ratio_bus;
   logic [`TVR_BUS_W-1:0] oldest;
   logic [`TVR_BUS_W-1:0] prefault;
   logic [`TVR_BUS_W-1:0] first_fault;
   logic [`TVR_BUS_W-1:0] fault;
   logic [`TVR_CNT_W-1:0] post_cnt;
   logic [`TVR_CNT_W-1:0] next_cnt;
   logic fault_done;
   logic trip_seen;
   logic counting;
   logic in_emit;
   logic [`TVR_REC_W-1:0] emit_idx;
   logic [1:0] emit_chan;
   logic [`TVR_PW-1:0] next_value;
   state_e state;

   assign sample_bus = {sample_c, sample_b, sample_a};
   assign ratio_bus = {ratio_c, ratio_b, ratio_a};
   assign start_edge = start & ~start_q;
   assign trip_edge = trip & ~trip_q;
   assign next_cnt = post_cnt + `TVR_CNT_W'(1);
   assign counting = (state == ST_WAIT) && sample_valid && !fault_done && !start_edge;
   assign in_emit = (state == ST_EMIT);
   assign emit_chan = (emit_idx >= `TVR_REC_W'(`TVR_REC_FAULT)) ?
                      2'(emit_idx - `TVR_REC_W'(`TVR_REC_FAULT)) : emit_idx[1:0];
   // Primary value is secondary times ratio; full-width product, no overflow
   assign next_value = `TVR_PW'(pick((emit_idx >= `TVR_REC_W'(`TVR_REC_FAULT)) ? fault : prefault, emit_chan)) *
                       `TVR_PW'(pick(ratio_bus, emit_chan));

   // Start and trip come from same-clock logic, so only edge history is kept
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         start_q <= 1'b0;
         trip_q <= 1'b0;
      end else begin
         start_q <= start;
         trip_q <= trip;
      end
   end

   sample_history u_history (
      .ref_clk(ref_clk),
      .srst(srst),
      .wr_en(sample_valid),
      .wr_data(sample_bus),
      .oldest(oldest)
   );

   // Capture: prefault from history at the edge, fault built from later samples
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         prefault <= '0;
         first_fault <= '0;
         fault <= '0;
         post_cnt <= '0;
         fault_done <= 1'b0;
      end else if (start_edge) begin
         prefault <= oldest;
         post_cnt <= '0;
         fault_done <= 1'b0;
      end else if (counting) begin
         post_cnt <= next_cnt;
         if (next_cnt == `TVR_CNT_W'(`TVR_F1_SAMPLES)) begin
            first_fault <= sample_bus;
         end
         if (next_cnt == `TVR_CNT_W'(`TVR_F2_SAMPLES)) begin
            fault <= mean_bus(first_fault, sample_bus);
            fault_done <= 1'b1;
         end
      end
   end

   // Trip may arrive before the 20 ms sample; it is remembered until then
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         trip_seen <= 1'b0;
      end else if (start_edge) begin
         trip_seen <= trip_edge; // Set wins over the clear of a restart
      end else if (state == ST_WAIT && trip_edge) begin
         trip_seen <= 1'b1;
      end else if (state != ST_WAIT) begin
         trip_seen <= 1'b0;
      end
   end

   // Sequencing; a start edge always wins and aborts an emission in flight
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         state <= ST_IDLE;
         emit_idx <= '0;
      end else begin
         case (state)
            ST_IDLE: begin
               if (start_edge) begin
                  state <= ST_WAIT;
               end
            end
            ST_WAIT: begin
               if (!start_edge && fault_done && (trip_seen || trip_edge)) begin
                  state <= ST_EMIT;
                  emit_idx <= '0;
               end
            end
            ST_EMIT: begin
               if (start_edge) begin
                  state <= ST_WAIT;
               end else if (emit_idx == `TVR_REC_W'(`TVR_REC_LAST)) begin
                  state <= ST_IDLE;
               end else begin
                  emit_idx <= emit_idx + `TVR_REC_W'(1);
               end
            end
            default: begin
               state <= ST_IDLE;
            end
         endcase
      end
   end

   // Event records are the block's only result; one record per cycle
   always_ff @(posedge ref_clk) begin
      if (srst) begin
         event_valid <= 1'b0;
         event_fault <= 1'b0;
         event_chan <= '0;
         event_value <= '0;
      end else begin
         event_valid <= in_emit && !start_edge;
         event_fault <= emit_idx >= `TVR_REC_W'(`TVR_REC_FAULT);
         event_chan <= emit_chan;
         event_value <= next_value;
      end
   end

   // Capture and emission checks; they watch internal state, so a restart mid-emission is allowed for
   a_prefault_latch: assert property (@(posedge ref_clk) disable iff (srst)
      start_edge |=> prefault == $past(oldest)) else $error("Prefault not taken from history");
   a_wait_entry: assert property (@(posedge ref_clk) disable iff (srst)
      start_edge |=> state == ST_WAIT) else $error("Start edge did not enter waiting");
   a_restart_clears: assert property (@(posedge ref_clk) disable iff (srst)
      start_edge |=> !fault_done && post_cnt == '0) else $error("Restart kept old capture");
   a_fault_mean: assert property (@(posedge ref_clk) disable iff (srst)
      (counting && next_cnt == `TVR_CNT_W'(`TVR_F2_SAMPLES))
      |=> fault_done && fault == mean_bus($past(first_fault), $past(sample_bus)))
      else $error("Fault value is not the mean");
   a_trip_emits: assert property (@(posedge ref_clk) disable iff (srst)
      (state == ST_WAIT && fault_done && trip_edge && !start_edge)
      |=> in_emit ##1 ($past(start_edge) || (event_valid && !event_fault && event_chan == 2'h0)))
      else $error("Trip did not emit prefault first");
   a_trip_held: assert property (@(posedge ref_clk) disable iff (srst)
      (state == ST_WAIT && trip_edge && !start_edge) |=> trip_seen)
      else $error("Early trip was not remembered");
   a_fault_records: assert property (@(posedge ref_clk) disable iff (srst)
      (in_emit && emit_idx == `TVR_REC_W'(`TVR_REC_FAULT) && !start_edge)
      |=> event_valid && event_fault && event_chan == 2'h0)
      else $error("Fault records do not follow prefault records");
   a_primary_value: assert property (@(posedge ref_clk) disable iff (srst)
      (in_emit && !start_edge) |=> event_valid && event_value == $past(next_value))
      else $error("Event value not scaled");
   a_only_emit: assert property (@(posedge ref_clk) disable iff (srst)
      event_valid |-> $past(in_emit)) else $error("Event outside emission");
   a_idle_trip: assert property (@(posedge ref_clk) disable iff (srst)
      (state == ST_IDLE && trip_edge && !start_edge) |=> state == ST_IDLE ##1 !event_valid)
      else $error("Trip without capture produced an event");
   a_emit_return: assert property (@(posedge ref_clk) disable iff (srst)
      (in_emit && emit_idx == `TVR_REC_W'(`TVR_REC_LAST) && !start_edge) |=> state == ST_IDLE)
      else $error("Emission did not return to idle");
endmodule

// ---- test/upstream_model.sv ----
`timescale 1ns/1ps
`include "trip_value_recorder_consts.svh"
module upstream_model (
   input wire logic ref_clk,
   input wire logic srst,
   output logic sample_valid = 1'b0,
   output logic [`TVR_SW-1:0] sample_a = 16'h0000,
   output logic [`TVR_SW-1:0] sample_b = 16'h0000,
   output logic [`TVR_SW-1:0] sample_c = 16'h0000,
   output int idx = -1
);
   logic [1:0] phase = 2'h0;

   // Distinct ramps per channel, so a swapped channel or history slot shows
   function automatic logic [`TVR_SW-1:0] sval(int ch, int k);
      case (ch)
         0: return 16'(k * 3 + 7);
         1: return 16'(1000 + k * 5);
         default: return 16'(60000 - k * 11);
      endcase
   endfunction

   // One sample every fourth clock; between pulses the data toggles so stale data never looks valid
   always @(negedge ref_clk) begin
      if (srst) begin
         phase <= 2'h0;
         idx <= -1;
         sample_valid <= 1'b0;
      end else begin
         phase <= phase + 2'h1;
         sample_valid <= (phase == 2'h0);
         if (phase == 2'h0) begin
            idx <= idx + 1;
            sample_a <= sval(0, idx + 1);
            sample_b <= sval(1, idx + 1);
            sample_c <= sval(2, idx + 1);
         end else begin
            sample_a <= ~sample_a;
            sample_b <= ~sample_b;
            sample_c <= ~sample_c;
         end
      end
   end
endmodule

// ---- test/trip_value_recorder_tb.sv ----
`timescale 1ns/1ps
`include "trip_value_recorder_consts.svh"
module trip_value_recorder_tb;
   import tvr_pkg::*;
   typedef struct packed {logic f; logic [1:0] ch; logic [31:0] v; int cyc;} rec_s;
   logic ref_clk = 1'b0;
   logic srst = 1'b1;
   logic start = 1'b0;
   logic trip = 1'b0;
   logic sample_valid, event_valid, event_fault;
   logic [`TVR_SW-1:0] sample_a, sample_b, sample_c;
   logic [`TVR_RW-1:0] ratio_a = 16'h0002;
   logic [`TVR_RW-1:0] ratio_b = 16'h0003;
   logic [`TVR_RW-1:0] ratio_c = 16'h0100;
   logic [1:0] event_chan;
   logic [`TVR_PW-1:0] event_value;
   int idx;
   int cyc = 0;
   int bad_count = 0;
   int check_count = 0;
   rec_s recs[$];

   upstream_model i_upstream_model (.ref_clk(ref_clk), .srst(srst), .sample_valid(sample_valid),
      .sample_a(sample_a), .sample_b(sample_b), .sample_c(sample_c), .idx(idx));
   trip_value_recorder i_trip_value_recorder (.ref_clk(ref_clk), .srst(srst), .start(start), .trip(trip),
      .sample_valid(sample_valid), .sample_a(sample_a), .sample_b(sample_b), .sample_c(sample_c),
      .ratio_a(ratio_a), .ratio_b(ratio_b), .ratio_c(ratio_c), .event_valid(event_valid),
      .event_fault(event_fault), .event_chan(event_chan), .event_value(event_value));

   initial forever #4 ref_clk = ~ref_clk;

   // Keep every record with the cycle it showed up in
   always @(posedge ref_clk) begin
      cyc <= cyc + 1;
      if (event_valid === 1'b1) recs.push_back({event_fault, event_chan, event_value, cyc});
   end

   task check_bits(string what, logic [31:0] exp, logic [31:0] got);
      check_count++;
      if (got !== exp) begin
         bad_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask

   task check_num(string what, int exp, int got);
      check_count++;
      if (got != exp) begin
         bad_count++;
         $display("unexpected %s: expected %0d, seen %0d", what, exp, got);
      end
   endtask

   task end_of_test;
      if (bad_count == 0 && check_count > 0) $display("Simulation passed");
      else $display("Simulation failed");
      $finish;
   endtask

   task wait_pulses(int n);
      repeat (n) begin
         @(posedge ref_clk);
         while (sample_valid !== 1'b1) @(posedge ref_clk);
      end
   endtask

   // Start rises just after a sample, so the newest history entry is known
   task pulse_start(output int n);
      wait_pulses(1);
      n = idx;
      @(negedge ref_clk);
      start <= 1'b1;
      repeat (3) @(negedge ref_clk);
      start <= 1'b0;
   endtask

   task raise_trip(output int t);
      @(negedge ref_clk);
      trip <= 1'b1;
      t = cyc;
      repeat (3) @(negedge ref_clk);
      trip <= 1'b0;
   endtask

   function automatic logic [31:0] scaled(int ch, logic [15:0] s);
      return 32'(s) * 32'(ch == 0 ? ratio_a : (ch == 1 ? ratio_b : ratio_c));
   endfunction

   // Six records: prefault a,b,c then fault a,b,c on consecutive cycles
   task expect_six(int n, int first);
      logic [16:0] sum;
      logic [15:0] s;
      check_num("record count", 6, recs.size());
      if (first < 0 && recs.size() > 0) first = recs[0].cyc;
      for (int i = 0; i < 6 && i < recs.size(); i++) begin
         if (i < 3) s = i_upstream_model.sval(i, n - 100);
         else begin
            sum = 17'(i_upstream_model.sval(i % 3, n + 10)) + 17'(i_upstream_model.sval(i % 3, n + 20));
            s = sum[16:1];
         end
         check_bits("record kind", 32'(i / 3), 32'(recs[i].f));
         check_bits("record channel", 32'(i % 3), 32'(recs[i].ch));
         check_bits("record value", scaled(i % 3, s), recs[i].v);
         check_num("record cycle", first + i, recs[i].cyc);
      end
      recs.delete();
   endtask

   task idle_trip;
      int t;
      raise_trip(t);
      repeat (10) @(negedge ref_clk);
      check_num("records in idle", 0, recs.size());
   endtask

   task basic_capture;
      int n, t;
      pulse_start(n);
      wait_pulses(21);
      raise_trip(t);
      repeat (12) @(negedge ref_clk);
      expect_six(n, t + 2);
      raise_trip(t);
      repeat (12) @(negedge ref_clk);
      check_num("records after emission", 0, recs.size());
   endtask

   // Second start overwrites the first; trip comes five samples after it, before the 10 ms sample
   task restart_capture;
      int n1, n2, t;
      ratio_b <= 16'h0011;
      pulse_start(n1);
      wait_pulses(8);
      pulse_start(n2);
      wait_pulses(5);
      raise_trip(t);
      wait_pulses(15);
      t = cyc; // Edge of the 20th post-start sample; the held trip fires three edges later
      wait_pulses(5);
      repeat (12) @(negedge ref_clk);
      expect_six(n2, t + 3);
   endtask

   initial begin
      repeat (20) @(negedge ref_clk);
      srst <= 1'b0;
      idle_trip();
      while (idx < 101) wait_pulses(1);
      basic_capture();
      restart_capture();
      end_of_test();
   end

   // The whole run needs about 700 clocks
   initial begin
      #160000;
      bad_count++;
      end_of_test();
   end
endmodule
